// >>> bench/acc_analog_model.sv
// Behavioural analog front end: mux, gain stage, sample and hold, comparator
`default_nettype none
module acc_analog_model #(
  parameter logic [9:0] OFFSET = 10'h005  // Residual offset code of the gain path
) (
  input  wire logic                clk_sys_in,  // System clock
  input  wire logic [9:0]          vin_in,      // Input level in code steps
  input  wire logic [9:0]          dac_in,      // Trial code from the converter
  input  wire logic                sample_in,   // Sample phase
  input  wire logic                power_in,    // Analog power
  input  wire acc_pkg::acc_route_s route_in,    // Routing controls
  output logic                     cmp_out      // Input above trial code
);
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  logic [9:0] held = 10'h000;  // Held level
  logic       cmp_q = 1'b0;    // Comparator state
  assign cmp_out = cmp_q;
  // Track input while sampling; tied gain inputs show only the offset
  always @(posedge clk_sys_in) begin
    if (sample_in) begin
      held <= (route_in.neg_is_pos && !route_in.gain_bypass) ? OFFSET : vin_in;
    end
    // Half-step bias keeps an exact level; noise while powered down
    cmp_q <= power_in ? ({held, 1'b1} > {dac_in, 1'b0}) : ~cmp_q;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the converter control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  localparam logic [9:0] OFF = 10'h005;  // Model offset code
  logic              clk_sys_in = 1'b0;  // System clock
  logic              rst_in = 1'b1;      // Reset
  logic [ADDR_W-1:0] addr = 6'h00;       // Address
  logic [DATA_W-1:0] wdata = 8'h00;      // Write data
  logic              wr = 1'b0;          // Write strobe
  logic              rd = 1'b0;          // Read strobe
  logic              ack = 1'b0;         // Interrupt serviced
  logic [9:0]        vin = 10'h000;      // Analog level
  logic              cmp;                // Comparator
  logic [DATA_W-1:0] rdata;              // Read data
  logic              irq;                // Interrupt
  logic [9:0]        dac;                // Trial code
  logic              sh;                 // Sample phase
  logic              aen;                // Analog power
  acc_route_s        route;              // Routing
  int                n_errors = 0;       // Mismatches
  int                comparisons = 0;    // Checks made
  int                cyc = 0;            // Cycles run
  integer            seed = 32'hcc9dea63; // Random seed

  acc_top i_acc_top (.clk_sys_in, .rst_in, .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .cmp_in(cmp), .irq_ack_in(ack), .rdata_out(rdata), .irq_out(irq), .dac_code_out(dac),
    .sample_hold_out(sh), .analog_enable_out(aen), .route_out(route));
  acc_analog_model #(.OFFSET(OFF)) i_acc_analog_model (.clk_sys_in, .vin_in(vin), .dac_in(dac),
    .sample_in(sh), .power_in(aen), .route_in(route), .cmp_out(cmp));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // Cut a hang short
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register write, one cycle
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  // Register read, data in the following cycle
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    d = rdata;
  endtask

  // Wait for the completion request, bounded
  task automatic wait_irq(output int t);
    repeat (2) @(posedge clk_sys_in);
    t = 2;
    while (irq !== 1'b1 && t < 2000) begin
      @(posedge clk_sys_in);
      t++;
    end
    chk("irq", t < 2000, 1'b1);
  endtask

  // Start, see busy, wait for done
  task automatic conv(input logic [7:0] c, output int t);
    logic [7:0] d;
    wr_reg(CTRL_STATUS_ADDR, c);
    rd_reg(CTRL_STATUS_ADDR, d);
    chk("busy", d[6], 1'b1);
    wait_irq(t);
  endtask

  // Read low then high and compare the pair
  task automatic res(input logic [9:0] v, input logic l);
    logic [7:0] lo;
    logic [7:0] hi;
    rd_reg(RESULT_LOW_ADDR, lo);
    rd_reg(RESULT_HIGH_ADDR, hi);
    chk("result", {hi, lo}, l ? {v, 6'h00} : {6'h00, v});
  endtask

  // Expected routing for a selection
  function automatic acc_route_s rt(input logic [1:0] rf, input logic [2:0] m);
    rt.ref_sel = rf;
    rt.ref_to_pin = rf[0];
    rt.channel = m[2] ? 2'h2 : m[1:0];
    rt.gain_bypass = ~m[2];
    rt.gain_20x = m[2] & m[0];
    rt.neg_is_pos = m[2] & ~m[1];
  endfunction

  // Counts and verdict
  task automatic results();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0] d;
    logic [2:0] m;
    logic [1:0] rf;
    logic       l;
    logic [9:0] v;
    int         t;
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int a = 4; a < 9; a++) begin
      rd_reg(6'(a), d);
      chk("reset read", d, 8'h00);
    end
    $display("test reset done");
    vin <= 10'h2a5;
    conv(8'hca, t);
    chk("extended", t >= 190 && t <= 215, 1'b1);
    rd_reg(CTRL_STATUS_ADDR, d);
    chk("ctrl done", d, 8'h9a);
    res(10'h2a5, 1'b0);
    wr_reg(CTRL_STATUS_ADDR, 8'h9a);
    repeat (2) @(posedge clk_sys_in);
    chk("irq clear", irq, 1'b0);
    conv(8'hca, t);
    chk("normal", t >= 94 && t <= 119, 1'b1);
    wr_reg(CTRL_STATUS_ADDR, 8'h9a);
    wr_reg(INPUT_SEL_ADDR, 8'h40);
    conv(8'hca, t);
    chk("ref change", t >= 190 && t <= 215, 1'b1);
    wr_reg(CTRL_STATUS_ADDR, 8'h9a);
    $display("test timing done");
    for (int i = 0; i < 8; i++) begin
      m = 3'($unsigned($random(seed)) % 8);
      rf = 2'($random(seed));
      l = 1'($random(seed));
      v = 10'($random(seed));
      vin <= v;
      wr_reg(INPUT_SEL_ADDR, {rf, l, 2'h0, m});
      conv(8'hca, t);
      chk("route", route, rt(rf, m));
      res(m[2] && !m[1] ? OFF : v, l);
      wr_reg(CTRL_STATUS_ADDR, 8'h9a);
    end
    $display("test random done");
    wr_reg(INPUT_SEL_ADDR, 8'h00);
    vin <= 10'h300;
    wr_reg(CTRL_STATUS_ADDR, 8'hca);
    wr_reg(INPUT_SEL_ADDR, 8'h04);
    wait_irq(t);
    res(10'h300, 1'b0);
    wr_reg(CTRL_STATUS_ADDR, 8'h9a);
    wr_reg(INPUT_SEL_ADDR, 8'h00);
    vin <= 10'h155;
    conv(8'hca, t);
    wr_reg(CTRL_STATUS_ADDR, 8'h9a);
    rd_reg(RESULT_LOW_ADDR, d);
    vin <= 10'h0aa;
    conv(8'hca, t);
    @(posedge clk_sys_in);
    ack <= 1'b1;
    @(posedge clk_sys_in);
    ack <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk("irq ack", irq, 1'b0);
    rd_reg(RESULT_HIGH_ADDR, d);
    chk("locked high", d, 8'h01);
    res(10'h155, 1'b0);
    conv(8'hca, t);
    wr_reg(CTRL_STATUS_ADDR, 8'h9a);
    res(10'h0aa, 1'b0);
    $display("test lock done");
    vin <= 10'h1c3;
    conv(8'hea, t);
    vin <= 10'h3c1;
    repeat (2) begin
      wr_reg(CTRL_STATUS_ADDR, 8'hfa);
      wait_irq(t);
    end
    rd_reg(CTRL_STATUS_ADDR, d);
    chk("free start", d[6], 1'b1);
    res(10'h3c1, 1'b0);
    wr_reg(CTRL_STATUS_ADDR, 8'h00);
    repeat (4) @(posedge clk_sys_in);
    wr_reg(CTRL_STATUS_ADDR, 8'h50);
    rd_reg(CTRL_STATUS_ADDR, d);
    chk("off ctrl", d, 8'h00);
    chk("off route", {aen, route}, 9'h000);
    $display("test free run and disable done");
    results();
  end
endmodule
`default_nettype wire

// >>> hdl/acc_pkg.sv
// Shared constants and types for the converter control block
`default_nettype none
package acc_pkg;
  // Register port, result, counter and prescaler widths
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RES_W  = 10;
  localparam int unsigned CNT_W  = 5;
  localparam int unsigned PRE_W  = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] RESULT_LOW_ADDR  = 6'h04;
  localparam logic [ADDR_W-1:0] RESULT_HIGH_ADDR = 6'h05;
  localparam logic [ADDR_W-1:0] CTRL_STATUS_ADDR = 6'h06;
  localparam logic [ADDR_W-1:0] INPUT_SEL_ADDR   = 6'h07;

  // Control/status field positions
  localparam int unsigned CS_ENABLE_BIT = 7;
  localparam int unsigned CS_START_BIT  = 6;
  localparam int unsigned CS_FREE_BIT   = 5;
  localparam int unsigned CS_DONE_BIT   = 4;
  localparam int unsigned CS_IE_BIT     = 3;
  localparam int unsigned CS_PRESC_LSB  = 0;

  // Input select field positions
  localparam int unsigned IS_REF_LSB  = 6;
  localparam int unsigned IS_LEFT_BIT = 5;
  localparam int unsigned IS_MUX_LSB  = 0;

  // Values after reset, and prescaler base divide
  localparam logic [2:0]       PRESC_RST  = 3'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  localparam logic [PRE_W-1:0] PRE_CNT_RST = 8'h00;
  localparam logic [PRE_W-1:0] PRE_BASE   = 8'h02;

  // Conversion lengths and sampling lead in converter clock cycles, top result bit
  localparam logic [CNT_W-1:0] NORM_CONV_CYCLES = 5'd13;
  localparam logic [CNT_W-1:0] EXT_CONV_CYCLES  = 5'd25;
  localparam logic [CNT_W-1:0] SAR_LEAD         = 5'd11;
  localparam logic [CNT_W-1:0] TOP_BIT          = 5'd9;

  // Reference selection codes
  localparam logic [1:0] REF_SUPPLY  = 2'h0;
  localparam logic [1:0] REF_PIN     = 2'h1;
  localparam logic [1:0] REF_INT     = 2'h2;
  localparam logic [1:0] REF_INT_CAP = 2'h3;

  // Conversion engine states
  typedef enum logic [2:0] {
    ACC_IDLE  = 3'b001,
    ACC_ARMED = 3'b010,
    ACC_CONV  = 3'b100
  } acc_state_e;

  // Requested or active selection
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [2:0] mux;
  } acc_sel_s;

  // Analog routing controls
  typedef struct packed {
    logic [1:0] ref_sel;
    logic       ref_to_pin;
    logic [1:0] channel;
    logic       gain_bypass;
    logic       gain_20x;
    logic       neg_is_pos;
  } acc_route_s;
endpackage
`default_nettype wire

// >>> hdl/acc_prescaler.sv
// Converter clock prescaler producing one-cycle tick pulses
`default_nettype none
module acc_prescaler (
  input  wire logic       clk_sys_in,  // System clock
  input  wire logic       rst_in,      // Synchronous reset
  input  wire logic       run_in,      // Converter enabled
  input  wire logic [2:0] sel_in,      // Division select
  output logic            tick_out     // Converter clock edge
);
  import acc_pkg::*;

  logic [PRE_W-1:0] cnt_reg;   // Division counter
  logic [PRE_W-1:0] cnt_next;
  logic             tick_reg;  // Registered tick
  logic             tick_next;
  logic [PRE_W-1:0] last_cnt;  // Terminal count

  // Count up to the selected divide, held at zero while stopped
  always_comb begin
    last_cnt  = PRE_W'((PRE_BASE << sel_in) - PRE_W'(1));
    cnt_next  = cnt_reg + PRE_W'(1);
    tick_next = 1'b0;
    if (!run_in) begin
      cnt_next = PRE_CNT_RST;
    end else if (cnt_reg >= last_cnt) begin
      cnt_next  = PRE_CNT_RST;
      tick_next = 1'b1;
    end
  end

  // Register the counter and tick
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_reg  <= PRE_CNT_RST;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;
endmodule
`default_nettype wire

// >>> hdl/acc_top.sv
// Successive approximation converter control with locked result registers
//
// Chosen here: the register addresses and the plain strobed port.
`default_nettype none
// How it works
// - Ten-bit successive approximation of selected input
// - Code zero is ground, top is reference minus step
// - Two-bit field picks supply, pin or internal reference
// - Differential pair amplified by one or twenty
// - Single-ended inputs bypass the gain amplifier
// - Same input on both sides measures offset
// - Free-run bit selects single or continuous mode
// - Free run refreshes results without new starts
// - Nothing happens until the enable bit is set
// - Start bit reads one while converting, then clears in single mode
// - Selection changes apply after current conversion
// - Result right-aligned, or left-aligned when selected
// - Low byte read locks both result registers
// - Completion while locked discards the new result
// - High byte read unlocks the result registers
// - Done flag set on every completion, even discarded
// - Thirteen cycles normally, twenty-five when extended
// - Completion writes result if unlocked, sets flag, clears start in single mode
// - Free run restarts immediately while start stays set
// - Prescaler runs only while enabled
module acc_top (
  input  wire logic                       clk_sys_in,        // System clock
  input  wire logic                       rst_in,            // Synchronous reset
  input  wire logic [acc_pkg::ADDR_W-1:0] addr_in,           // Register address
  input  wire logic [acc_pkg::DATA_W-1:0] wdata_in,          // Write data
  input  wire logic                       wr_in,             // Write strobe
  input  wire logic                       rd_in,             // Read strobe
  input  wire logic                       cmp_in,            // Comparator from analog core
  input  wire logic                       irq_ack_in,        // Interrupt serviced
  output logic [acc_pkg::DATA_W-1:0]      rdata_out,         // Read data, cycle after strobe
  output logic                            irq_out,           // Conversion complete request
  output logic [acc_pkg::RES_W-1:0]       dac_code_out,      // Trial code to internal DAC
  output logic                            sample_hold_out,   // Sample phase active
  output logic                            analog_enable_out, // Analog power on
  output acc_pkg::acc_route_s             route_out          // Reference and mux routing
);
  import acc_pkg::*;

  // Register file state
  logic             enable_reg, enable_next;   // Converter enable
  logic             start_reg, start_next;     // Conversion start / busy
  logic             free_reg, free_next;       // Free-running select
  logic             done_reg, done_next;       // Conversion done flag
  logic             ie_reg, ie_next;           // Interrupt enable
  logic [2:0]       presc_reg, presc_next;     // Prescaler select
  acc_sel_s         sel_req_reg, sel_req_next; // Requested selection
  logic             left_reg, left_next;       // Left alignment
  logic [RES_W-1:0] result_reg, result_next;   // Stored conversion result
  logic             lock_reg, lock_next;       // Result lock
  logic [DATA_W-1:0] rdata_reg, rdata_next;    // Read data
  logic             irq_reg, irq_next;         // Interrupt output

  // Conversion engine state
  acc_state_e       state_reg, state_next;     // Engine state
  logic [CNT_W-1:0] cnt_reg, cnt_next;         // Cycle within conversion
  logic [CNT_W-1:0] len_reg, len_next;         // Length of this conversion
  logic [RES_W-1:0] sar_reg, sar_next;         // Approximation register
  acc_sel_s         act_reg, act_next;         // Selection in effect
  logic             first_reg, first_next;     // Next conversion extended
  logic             phase_reg, phase_next;     // Converter clock parity
  logic             sh_reg, sh_next;           // Sample phase
  logic             aen_reg, aen_next;         // Analog enable
  acc_route_s       route_reg, route_next;     // Routing outputs

  // Comparator synchroniser
  logic             cmp_s1_reg, cmp_s2_reg, cmp_s3_reg; // Three-stage chain
  logic             cmp_lvl_reg, cmp_lvl_next;          // Accepted level

  // Decodes and events
  logic             tick;      // Converter clock edge
  logic             wr_cs;     // Write to control/status
  logic             wr_is;     // Write to input select
  logic             rd_low;    // Read of result low byte
  logic             rd_high;   // Read of result high byte
  logic             done_evt;  // Conversion finishes this cycle
  logic             capture;   // Take selection and arm
  logic             ext;       // Captured conversion is extended
  logic [CNT_W-1:0] s0;        // First resolving cycle
  logic [CNT_W-1:0] offs;      // Resolving step number
  logic [3:0]       bidx;      // Bit being resolved

  // Prescaler held in reset while disabled
  acc_prescaler u_prescaler (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .run_in     (enable_reg),
    .sel_in     (presc_reg),
    .tick_out   (tick)
  );

  // Bus strobe decode
  always_comb begin
    wr_cs   = wr_in && (addr_in == CTRL_STATUS_ADDR);
    wr_is   = wr_in && (addr_in == INPUT_SEL_ADDR);
    rd_low  = rd_in && (addr_in == RESULT_LOW_ADDR);
    rd_high = rd_in && (addr_in == RESULT_HIGH_ADDR);
    done_evt = (state_reg == ACC_CONV) && tick && (cnt_reg == len_reg - CNT_W'(1));
  end

  // Comparator accepted when the last two stages agree
  always_comb begin
    cmp_lvl_next = cmp_lvl_reg;
    if (cmp_s2_reg == cmp_s3_reg) begin
      cmp_lvl_next = cmp_s2_reg;
    end
  end

  // Synchroniser registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cmp_s1_reg  <= 1'b0;
      cmp_s2_reg  <= 1'b0;
      cmp_s3_reg  <= 1'b0;
      cmp_lvl_reg <= 1'b0;
    end else begin
      cmp_s1_reg  <= cmp_in;
      cmp_s2_reg  <= cmp_s1_reg;
      cmp_s3_reg  <= cmp_s2_reg;
      cmp_lvl_reg <= cmp_lvl_next;
    end
  end

  // Register file next values
  always_comb begin
    enable_next  = enable_reg;
    start_next   = start_reg;
    free_next    = free_reg;
    done_next    = done_reg;
    ie_next      = ie_reg;
    presc_next   = presc_reg;
    sel_req_next = sel_req_reg;
    left_next    = left_reg;
    result_next  = result_reg;
    lock_next    = lock_reg;
    rdata_next   = '0;
    // Control/status write
    if (wr_cs) begin
      enable_next = wdata_in[CS_ENABLE_BIT];
      free_next   = wdata_in[CS_FREE_BIT];
      ie_next     = wdata_in[CS_IE_BIT];
      presc_next  = wdata_in[CS_PRESC_LSB +: 3];
    end
    // Hardware clears start at single-mode completion
    if (done_evt && !free_reg) begin
      start_next = 1'b0;
    end
    // Software start wins over the hardware clear
    if (wr_cs && wdata_in[CS_START_BIT] && wdata_in[CS_ENABLE_BIT]) begin
      start_next = 1'b1;
    end
    // Disabling aborts any conversion
    if (!enable_next) begin
      start_next = 1'b0;
    end
    // Flag cleared by write of one or by service
    if ((wr_cs && wdata_in[CS_DONE_BIT]) || irq_ack_in) begin
      done_next = 1'b0;
    end
    // Completion sets the flag even when discarded, set wins
    if (done_evt) begin
      done_next = 1'b1;
    end
    // Selection write, held until the engine captures it
    if (wr_is) begin
      sel_req_next.ref_sel = wdata_in[IS_REF_LSB +: 2];
      sel_req_next.mux     = wdata_in[IS_MUX_LSB +: 3];
      left_next            = wdata_in[IS_LEFT_BIT];
    end
    // Result written only when unlocked
    if (done_evt && !lock_reg && !rd_low) begin
      result_next = sar_reg;
    end
    // Lock on low read, release on high read
    if (rd_low) begin
      lock_next = 1'b1;
    end else if (rd_high) begin
      lock_next = 1'b0;
    end
    // Read mux, alignment applied at read time
    if (rd_in) begin
      case (addr_in)
        RESULT_LOW_ADDR: begin
          rdata_next = left_reg ? {result_reg[1:0], 6'h00} : result_reg[7:0];
        end
        RESULT_HIGH_ADDR: begin
          rdata_next = left_reg ? result_reg[9:2] : {6'h00, result_reg[9:8]};
        end
        CTRL_STATUS_ADDR: begin
          rdata_next = {enable_reg, start_reg, free_reg, done_reg, ie_reg, presc_reg};
        end
        INPUT_SEL_ADDR: begin
          rdata_next = {sel_req_reg.ref_sel, left_reg, 2'b00, sel_req_reg.mux};
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
    irq_next = done_next && ie_next;
  end

  // Register file registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      enable_reg  <= 1'b0;
      start_reg   <= 1'b0;
      free_reg    <= 1'b0;
      done_reg    <= 1'b0;
      ie_reg      <= 1'b0;
      presc_reg   <= PRESC_RST;
      sel_req_reg <= '0;
      left_reg    <= 1'b0;
      result_reg  <= RESULT_RST;
      lock_reg    <= 1'b0;
      rdata_reg   <= '0;
      irq_reg     <= 1'b0;
    end else begin
      enable_reg  <= enable_next;
      start_reg   <= start_next;
      free_reg    <= free_next;
      done_reg    <= done_next;
      ie_reg      <= ie_next;
      presc_reg   <= presc_next;
      sel_req_reg <= sel_req_next;
      left_reg    <= left_next;
      result_reg  <= result_next;
      lock_reg    <= lock_next;
      rdata_reg   <= rdata_next;
      irq_reg     <= irq_next;
    end
  end

  // Conversion engine next values
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    len_next   = len_reg;
    sar_next   = sar_reg;
    act_next   = act_reg;
    first_next = first_reg;
    phase_next = phase_reg;
    sh_next    = sh_reg;
    aen_next   = enable_reg;
    capture    = 1'b0;
    s0         = len_reg - SAR_LEAD;
    offs       = cnt_reg - s0;
    bidx       = 4'(TOP_BIT - offs);
    // Extended after enable, reference change or new differential pair
    ext = first_reg || (sel_req_reg.ref_sel != act_reg.ref_sel) ||
          (sel_req_reg.mux[2] && (sel_req_reg.mux != act_reg.mux));
    if (tick) begin
      phase_next = !phase_reg;
    end
    case (state_reg)
      ACC_IDLE: begin
        if (start_reg) begin
          capture = 1'b1;
        end
      end
      ACC_ARMED: begin
        // Differential conversions start on every other converter edge
        if (tick && (!act_reg.mux[2] || !phase_reg)) begin
          state_next = ACC_CONV;
          cnt_next   = '0;
          sar_next   = '0;
          sh_next    = 1'b1;
        end
      end
      ACC_CONV: begin
        if (done_evt) begin
          sh_next = 1'b0;
          if (free_reg && start_next) begin
            capture = 1'b1;
          end else begin
            state_next = ACC_IDLE;
          end
        end else if (tick) begin
          cnt_next = cnt_reg + CNT_W'(1);
          // End of sampling, first trial bit
          if (cnt_reg + CNT_W'(1) == s0) begin
            sh_next           = 1'b0;
            sar_next[RES_W-1] = 1'b1;
          end
          // Keep bit when input is above trial, then try next
          if (cnt_reg >= s0) begin
            sar_next[bidx] = cmp_lvl_reg;
            if (bidx != 4'd0) begin
              sar_next[bidx-4'd1] = 1'b1;
            end
          end
        end
      end
      default: begin
        state_next = ACC_IDLE;
      end
    endcase
    // Selection taken only between conversions
    if (capture) begin
      state_next = ACC_ARMED;
      act_next   = sel_req_reg;
      len_next   = ext ? EXT_CONV_CYCLES : NORM_CONV_CYCLES;
      first_next = 1'b0;
    end
    // Disabled converter stays idle and forgets its history
    if (!enable_reg) begin
      state_next = ACC_IDLE;
      phase_next = 1'b0;
      first_next = 1'b1;
      sh_next    = 1'b0;
      cnt_next   = '0;
    end
    // Routing decode, inactive until enabled
    route_next             = '0;
    if (enable_reg) begin
      route_next.ref_sel     = act_next.ref_sel;
      route_next.ref_to_pin  = (act_next.ref_sel == REF_PIN) || (act_next.ref_sel == REF_INT_CAP);
      route_next.channel     = act_next.mux[2] ? 2'd2 : act_next.mux[1:0];
      route_next.gain_bypass = !act_next.mux[2];
      route_next.gain_20x    = act_next.mux[2] && act_next.mux[0];
      route_next.neg_is_pos  = act_next.mux[2] && !act_next.mux[1];
    end
  end

  // Conversion engine registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= ACC_IDLE;
      cnt_reg   <= '0;
      len_reg   <= NORM_CONV_CYCLES;
      sar_reg   <= '0;
      act_reg   <= '0;
      first_reg <= 1'b1;
      phase_reg <= 1'b0;
      sh_reg    <= 1'b0;
      aen_reg   <= 1'b0;
      route_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      len_reg   <= len_next;
      sar_reg   <= sar_next;
      act_reg   <= act_next;
      first_reg <= first_next;
      phase_reg <= phase_next;
      sh_reg    <= sh_next;
      aen_reg   <= aen_next;
      route_reg <= route_next;
    end
  end

  // Outputs straight from registers
  assign rdata_out         = rdata_reg;
  assign irq_out           = irq_reg;
  assign dac_code_out      = sar_reg;
  assign sample_hold_out   = sh_reg;
  assign analog_enable_out = aen_reg;
  assign route_out         = route_reg;

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_start_clear;
    done_evt && !free_reg && !wr_cs |=> !start_reg && state_reg == ACC_IDLE;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start not cleared");
  property p_locked_keep;
    done_evt && (lock_reg || rd_low) |=> $stable(result_reg);
  endproperty
  a_locked_keep: assert property (p_locked_keep) else $error("locked result changed");
  property p_result_write;
    done_evt && !lock_reg && !rd_low |=> result_reg == $past(sar_reg);
  endproperty
  a_result_write: assert property (p_result_write) else $error("result not written");
  property p_flag_set;
    done_evt |=> done_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");
  property p_disabled_idle;
    !enable_reg |=> state_reg == ACC_IDLE && !sample_hold_out && route_out == '0;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("activity while disabled");
  property p_lock;
    (rd_low || (lock_reg && !rd_high)) |=> lock_reg;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not held");
  property p_unlock;
    rd_high |=> !lock_reg;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock not released");
  property p_irq;
    irq_out == (done_reg && ie_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");
  property p_sel_hold;
    state_reg == ACC_CONV && $past(state_reg) == ACC_CONV |-> $stable(act_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed mid conversion");
  property p_len;
    capture && enable_reg |=> len_reg == ($past(ext) ? EXT_CONV_CYCLES : NORM_CONV_CYCLES);
  endproperty
  a_len: assert property (p_len) else $error("wrong conversion length");
  property p_presc_hold;
    !enable_reg ##1 !enable_reg |-> !tick;
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("prescaler ticks while disabled");
  property p_free_restart;
    done_evt && free_reg && start_next |=> state_reg == ACC_ARMED && start_reg;
  endproperty
  a_free_restart: assert property (p_free_restart) else $error("free run did not restart");
  property p_right_low;
    rd_low && !left_reg |=> rdata_out == $past(result_reg[7:0]);
  endproperty
  a_right_low: assert property (p_right_low) else $error("low byte misaligned");

  c_single: cover property (done_evt && !free_reg);
  c_free: cover property (done_evt && free_reg ##1 state_reg == ACC_ARMED);
  c_discard: cover property (done_evt && lock_reg);
  c_ext: cover property (done_evt && len_reg == EXT_CONV_CYCLES);
endmodule
`default_nettype wire
